// ---- logic/core_ctl_pkg.sv ----
// Purpose: Shared constants and types for the pipeline hold/prefix control
// Assumes: Single 10 MHz clock, synchronous active-high reset
// Notes:   Bus status encodings are plain choices held here once
package core_ctl_pkg;

    // ------------------------------------------------------------------
    // Widths and limits
    // ------------------------------------------------------------------
    localparam int ADDR_W       = 20;
    localparam int DATA_W       = 16;
    localparam int MAX_PREFIX   = 7;
    localparam int PFX_CNT_W    = 4;
    localparam int PIPE_DEPTH   = 3;

    // ------------------------------------------------------------------
    // Bus status codes, bit 3 marks I/O cycles
    // ------------------------------------------------------------------
    localparam logic [3:0] BS_IDLE    = 4'hF;
    localparam logic [3:0] BS_MEM_RD  = 4'h1;
    localparam logic [3:0] BS_MEM_WR  = 4'h2;
    localparam logic [3:0] BS_IO_RD   = 4'h9;
    localparam logic [3:0] BS_IO_WR   = 4'hA;
    localparam logic [3:0] BS_INTA    = 4'h4;
    localparam int         BS_IO_BIT  = 3;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_RST = 20'h00000;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

    // Kinds of bus request from the execution pipeline
    typedef enum logic [1:0] {
        REQ_MEM_RD,
        REQ_MEM_WR,
        REQ_IO_RD,
        REQ_IO_WR
    } req_kind_e;

    // One bus request from the pipeline
    typedef struct packed {
        req_kind_e           kind;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
        logic                word;
        logic                locked;
    } bus_req_s;

    // Decoded instruction summary from the pipeline
    typedef struct packed {
        logic                   valid;
        logic [PFX_CNT_W-1:0]   prefixes;
        logic                   lock_pfx;
        logic                   accesses_bus;
        logic                   legacy_op;
    } instr_info_s;

endpackage : core_ctl_pkg

// ---- logic/core_hold_ctl.sv ----
// Purpose: Bus cycle, hold, prefix and interrupt control of the core
// Assumes: Pipeline supplies requests and decoded instruction summaries
// Notes:   Each bus cycle takes one clock; odd words split in two cycles
//
// Function
// - Grant hold under lock prefix when the instruction makes no bus access.
// - Never grant hold between the two halves of an odd-address word.
// - Leaving hold in standby emits no status; status stays idle.
// - Accept up to seven prefixes, redundant ones too, and execute correctly.
// - Legacy unsupported opcodes give undefined results, not legacy behaviour.
// - Interrupts may wait for in-flight instructions; I/O-tied ones do not.
// - Status bit three separates I/O cycles from memory cycles.
// - One clock per bus cycle, 20-bit address, separate 16-bit data buses.
`timescale 1ns/100ps
module core_hold_ctl
    import core_ctl_pkg::*;
#(
    parameter int PIPE_STAGES = PIPE_DEPTH
) (
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               srst,
    // Pipeline request side
    input  wire bus_req_s           req,
    input  wire logic               req_valid,
    output      logic               req_ready,
    input  wire instr_info_s        instr,
    input  wire logic               instr_done,
    input  wire logic               standby,
    // Interrupt side
    input  wire logic               irq,
    input  wire logic               irq_io_tied,
    output      logic               irq_ack,
    output      logic               undef_op,
    output      logic               prefix_ok,
    // External bus
    output      logic [ADDR_W-1:0]  bus_addr,
    output      logic [DATA_W-1:0]  bus_dout,
    input  wire logic [DATA_W-1:0]  bus_din,
    output      logic [3:0]         bus_status,
    output      logic               bus_lock_out_n,
    output      logic               bus_ube_n,
    output      logic [DATA_W-1:0]  rdata,
    output      logic               rdata_valid,
    // Hold handshake
    input  wire logic               hold_req,
    output      logic               hold_ack
);

    // Wait counter is four bits wide; refuse depths it cannot count
    // at elaboration rather than wrap silently at run time
    if (PIPE_STAGES < 1 || PIPE_STAGES > 15) begin : g_stage_check
        $error("PIPE_STAGES out of range");
    end

    typedef enum logic [1:0] {ST_IDLE, ST_SECOND, ST_HOLD} bus_st_e;

    // Sequencer state, split word copy and interrupt wait counter
    bus_st_e           st_q;
    logic [7:0]        hi_byte_q;
    bus_req_s          split_q;
    logic [3:0]        irq_wait_q;
    logic              irq_pend_q;
    logic              join_q;

    // Status code for a request kind; bit 3 set for I/O cycles
    function automatic logic [3:0] status_of(input req_kind_e k);
        case (k)
            REQ_MEM_RD: status_of = BS_MEM_RD;
            REQ_MEM_WR: status_of = BS_MEM_WR;
            REQ_IO_RD:  status_of = BS_IO_RD;
            default:    status_of = BS_IO_WR;
        endcase
    endfunction : status_of

    // ------------------------------------------------------------------
    // Bus cycle sequencing
    // ------------------------------------------------------------------
    logic odd_word;
    logic lock_ok;
    assign odd_word = req.word && req.addr[0];
    // Lock only asserts when the locked instruction really uses the bus
    assign lock_ok  = req.locked && instr.accesses_bus;

    // Bus sequencer: one cycle per clock, split odd words, hold at boundary
    // Hold and cycle outputs change on one edge, never inside a cycle
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_q           <= ST_IDLE;
            bus_addr       <= ADDR_RST;
            bus_dout       <= DATA_RST;
            bus_status     <= BS_IDLE;
            bus_lock_out_n <= 1'b1;
            bus_ube_n      <= 1'b1;
            hold_ack       <= 1'b0;
            req_ready      <= 1'b0;
            split_q        <= '0;
        end else begin
            req_ready  <= 1'b0;
            bus_status <= BS_IDLE;
            case (st_q)
                ST_IDLE: begin
                    // Hold wins at a boundary unless a locked access runs
                    if (hold_req && !(req_valid && lock_ok)) begin
                        st_q     <= ST_HOLD;
                        hold_ack <= 1'b1;
                        bus_lock_out_n <= 1'b1;
                    end else if (req_valid && !req_ready && !standby) begin
                        // A set req_ready means the valid seen now belongs
                        // to the request just finished; standby issues none
                        bus_addr       <= req.addr;
                        bus_status     <= status_of(req.kind);
                        bus_lock_out_n <= !lock_ok;
                        if (odd_word) begin
                            // Low byte first, on upper lane of odd address
                            bus_dout  <= {req.wdata[7:0], 8'h00};
                            bus_ube_n <= 1'b0;
                            split_q   <= req;
                            st_q      <= ST_SECOND;
                        end else begin
                            bus_dout  <= req.wdata;
                            bus_ube_n <= !(req.word || req.addr[0]);
                            req_ready <= 1'b1;
                        end
                    end else begin
                        bus_lock_out_n <= 1'b1;
                    end
                end
                ST_SECOND: begin
                    // Second half always follows; hold waits until done
                    bus_addr   <= split_q.addr + 20'h00001;
                    bus_dout   <= {8'h00, split_q.wdata[15:8]};
                    bus_ube_n  <= 1'b1;
                    bus_status <= status_of(split_q.kind);
                    req_ready  <= 1'b1;
                    st_q       <= ST_IDLE;
                end
                ST_HOLD: begin
                    // No cycle starts while granted; release shows idle
                    bus_status <= BS_IDLE;
                    if (!hold_req) begin
                        hold_ack <= 1'b0;
                        st_q     <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
            // Standby keeps status idle, also on return from hold, except for the second half of a split word
            if (standby && st_q != ST_SECOND)
                bus_status <= BS_IDLE;
        end
    end

    // ------------------------------------------------------------------
    // Read data assembly
    // ------------------------------------------------------------------
    // Collect read data; the second half of an odd word joins two bytes
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            hi_byte_q   <= 8'h00;
            join_q      <= 1'b0;
            rdata       <= DATA_RST;
            rdata_valid <= 1'b0;
        end else begin
            rdata_valid <= 1'b0;
            // Marks the cycle that follows the first half of a split word
            join_q      <= (st_q == ST_SECOND);
            if (st_q == ST_SECOND) begin
                // First half comes on the upper lane: low byte of the word
                hi_byte_q <= bus_din[15:8];
            end else if (bus_status == BS_MEM_RD
                         || bus_status == BS_IO_RD) begin
                rdata_valid <= 1'b1;
                rdata <= join_q ? {bus_din[7:0], hi_byte_q} : bus_din;
            end
        end
    end

    // ------------------------------------------------------------------
    // Decode checks
    // ------------------------------------------------------------------
    // Prefix count check and unsupported opcode flag
    // Over-long prefix runs are a software fault; the flag only reports it
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            prefix_ok <= 1'b1;
            undef_op  <= 1'b0;
        end else if (instr.valid) begin
            prefix_ok <= instr.prefixes <= PFX_CNT_W'(MAX_PREFIX);
            undef_op  <= instr.legacy_op;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt acknowledge latency
    // ------------------------------------------------------------------
    // Pending interrupt waits for in-flight instructions unless I/O-tied
    // I/O-tied requests retire with their own cycle, so they skip the wait
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irq_pend_q <= 1'b0;
            irq_wait_q <= 4'h0;
            irq_ack    <= 1'b0;
        end else begin
            irq_ack <= 1'b0;
            if (irq && !irq_pend_q && !irq_ack) begin
                irq_pend_q <= 1'b1;
                irq_wait_q <= irq_io_tied ? 4'h0 : 4'(PIPE_STAGES);
            end else if (irq_pend_q) begin
                if (irq_wait_q == 4'h0) begin
                    irq_ack    <= 1'b1;
                    irq_pend_q <= 1'b0;
                end else if (instr_done) begin
                    irq_wait_q <= irq_wait_q - 4'h1;
                end
            end
        end
    end

endmodule : core_hold_ctl

// ---- sim/core_hold_ctl_assertions.sv ----
// Purpose: Timing checks on hold, bus status and decode outputs
// Assumes: One clock clk_sys, srst synchronous active high
// Notes:   Bound to every core_hold_ctl instance
`timescale 1ns/100ps
module core_hold_ctl_assertions
    import core_ctl_pkg::*;
(
    // Clock, reset and inputs
    input wire logic              clk_sys,
    input wire logic              srst,
    input wire bus_req_s          req,
    input wire logic              req_valid,
    input wire instr_info_s       instr,
    input wire logic              standby,
    input wire logic              hold_req,
    // Outputs watched
    input wire logic              req_ready,
    input wire logic              undef_op,
    input wire logic              prefix_ok,
    input wire logic [ADDR_W-1:0] bus_addr,
    input wire logic [3:0]        bus_status,
    input wire logic              bus_lock_out_n,
    input wire logic              hold_ack
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    // First half of an odd-address word on the bus
    sequence odd_first_s;
        req_valid && req.word && req.addr[0] && bus_status != BS_IDLE
            && bus_addr == req.addr;
    endsequence
    split_no_hold_a: assert property (odd_first_s |=> !hold_ack)
        else $error("hold granted inside split word");
    hold_idle_a: assert property (hold_ack |-> bus_status == BS_IDLE)
        else $error("bus cycle while hold granted");
    hold_cause_a: assert property ($rose(hold_ack) |-> $past(hold_req))
        else $error("hold granted without request");
    hold_drop_a: assert property (hold_ack && !hold_req |=> !hold_ack)
        else $error("hold kept after request dropped");
    lock_quiet_a: assert property (
        !instr.accesses_bus [*2] |-> bus_lock_out_n)
        else $error("lock low without bus access");
    standby_idle_a: assert property (
        standby [*2] ##0 !req_ready |-> bus_status == BS_IDLE)
        else $error("status shown in standby");
    io_bit_a: assert property (
        bus_status != BS_IDLE && bus_status != BS_INTA
        |-> bus_status[BS_IO_BIT] == $past(req.kind[1]))
        else $error("bit 3 disagrees with cycle kind");
    ready_cycle_a: assert property (
        req_ready |-> bus_status != BS_IDLE)
        else $error("request finished without a bus cycle");
    prefix_lim_a: assert property (instr.valid |=>
        prefix_ok == ($past(instr.prefixes) <= MAX_PREFIX))
        else $error("prefix flag wrong");
    legacy_op_a: assert property (
        instr.valid && instr.legacy_op |=> undef_op)
        else $error("legacy opcode not flagged");
endmodule : core_hold_ctl_assertions

bind core_hold_ctl core_hold_ctl_assertions core_hold_ctl_assertions_i (.*);

// ---- sim/bus_dev_model.sv ----
// Purpose: Memory and I/O device on the far side of the bus
// Assumes: Reads answered within the one-clock bus cycle
// Notes:   Read data is the address folded with a fixed pattern
`timescale 1ns/100ps
module bus_dev_model
    import core_ctl_pkg::*;
(
    // Bus from the core
    input  wire logic              clk_sys,
    input  wire logic [ADDR_W-1:0] bus_addr,
    input  wire logic [3:0]        bus_status,
    // Data back to the core
    output      logic [DATA_W-1:0] bus_din
);
    logic              rd;
    logic [DATA_W-1:0] idle_q = 16'h0F0F;
    // Answer reads at once, scramble the released bus otherwise
    assign rd = bus_status == BS_MEM_RD || bus_status == BS_IO_RD;
    assign bus_din = rd ? bus_addr[15:0] ^ 16'h5A5A : idle_q;
    always_ff @(posedge clk_sys) begin
        idle_q <= ~bus_din;
    end
endmodule : bus_dev_model

// ---- sim/tb_top.sv ----
// Purpose: Self-checking bench for the hold and prefix control
// Assumes: 10 MHz clk_sys, srst held for ten cycles
// Notes:   Inputs change by non-blocking assignment at rising edges
`timescale 1ns/100ps
module tb_top
    import core_ctl_pkg::*;
;
    logic clk_sys, srst, req_valid, instr_done, standby, irq, irq_io_tied;
    logic hold_req, req_ready, irq_ack, undef_op, prefix_ok, hold_ack;
    logic bus_lock_out_n, bus_ube_n, rdata_valid;
    logic [3:0] bus_status;
    logic [ADDR_W-1:0] bus_addr;
    logic [DATA_W-1:0] bus_dout, bus_din, rdata;
    bus_req_s req;
    instr_info_s instr;
    int err_total, compares;
    core_hold_ctl core_hold_ctl_i (.*);
    bus_dev_model bus_dev_model_i (.*);
    // Shared helpers
    task automatic chk(input bit ok, input string msg);
        compares++;
        if (!ok) begin
            err_total++;
            $display("mismatch %0t %s", $time, msg);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick
    task automatic final_report;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report
    task automatic wait_hold(input logic lvl);
        bit ok = 0;
        repeat (4) begin
            tick(1);
            ok |= hold_ack === lvl;
            if (ok) break;
        end
        chk(ok, "hold acknowledge");
    endtask : wait_hold
    // One word request, with hold raised once it is taken
    task automatic bus_op(input req_kind_e k, input logic [19:0] a,
                          input logic [3:0] s, input bit hold);
        bit seen = 0, two = 0, held = 0, got = 0;
        bit rd = (k == REQ_MEM_RD || k == REQ_IO_RD);
        logic [15:0] d = ~a[15:0];
        logic [15:0] e0 = a[15:0] ^ 16'h5A5A;
        logic [15:0] e1 = (a[15:0] + 16'h0001) ^ 16'h5A5A;
        logic [15:0] exp = a[0] ? {e1[7:0], e0[15:8]} : e0;
        req <= '{k, a, d, 1'b1, 1'b0};
        req_valid <= 1'b1;
        tick(1);
        hold_req <= hold;
        repeat (6) begin
            tick(1);
            seen |= bus_status === s && bus_addr === a && bus_ube_n === 1'b0
                    && (rd || bus_dout === (a[0] ? {d[7:0], 8'h00} : d));
            two |= bus_status === s && bus_addr === a + 20'h00001
                   && bus_ube_n === 1'b1
                   && (rd || bus_dout === {8'h00, d[15:8]});
            held |= hold_ack === 1'b1;
            got |= rdata_valid === 1'b1 && rdata === exp;
            if (req_ready === 1'b1) break;
        end
        req_valid <= 1'b0;
        tick(1);
        got |= rdata_valid === 1'b1 && rdata === exp;
        chk(seen, "status or address");
        chk(two || !a[0], "second half of odd word");
        chk(!held, "hold inside bus cycle");
        if (rd) chk(got, "read data");
    endtask : bus_op
    task automatic t_kinds;
        req_kind_e k[4] = '{REQ_MEM_RD, REQ_MEM_WR, REQ_IO_RD, REQ_IO_WR};
        logic [3:0] s[4] = '{BS_MEM_RD, BS_MEM_WR, BS_IO_RD, BS_IO_WR};
        foreach (k[i]) bus_op(k[i], 20'(20'hA1240 + 4 * i), s[i], 0);
        bus_op(REQ_MEM_RD, 20'h10F03, BS_MEM_RD, 0);
        $display("test kinds done");
    endtask : t_kinds
    task automatic t_split;
        bus_op(REQ_MEM_WR, 20'h00F01, BS_MEM_WR, 1);
        wait_hold(1'b1);
        chk(bus_status === BS_IDLE, "status in hold");
        // A pending request must not show on the bus in standby
        req <= '{REQ_MEM_RD, 20'h00100, 16'h0000, 1'b1, 1'b0};
        req_valid <= 1'b1;
        standby <= 1'b1;
        hold_req <= 1'b0;
        wait_hold(1'b0);
        repeat (4) begin
            tick(1);
            chk(bus_status === BS_IDLE && req_ready === 1'b0,
                "status in standby");
        end
        req_valid <= 1'b0;
        standby <= 1'b0;
        $display("test split and standby done");
    endtask : t_split
    task automatic t_lock;
        tick(1);
        // Lock prefix on an instruction without bus access: hold still wins
        instr <= '{1'b1, 4'h1, 1'b1, 1'b0, 1'b0};
        req <= '{REQ_MEM_WR, 20'h00200, 16'h1234, 1'b1, 1'b1};
        req_valid <= 1'b1;
        hold_req <= 1'b1;
        wait_hold(1'b1);
        chk(bus_lock_out_n === 1'b1, "lock output low");
        hold_req <= 1'b0;
        wait_hold(1'b0);
        tick(1);
        chk(req_ready === 1'b1 && bus_lock_out_n === 1'b1,
            "lock without bus use");
        // Same request on a bus-using instruction: lock low, hold waits
        req_valid <= 1'b0;
        instr <= '{1'b1, 4'h1, 1'b1, 1'b1, 1'b0};
        tick(1);
        req_valid <= 1'b1;
        hold_req <= 1'b1;
        tick(2);
        chk(req_ready === 1'b1 && bus_lock_out_n === 1'b0
            && hold_ack === 1'b0, "locked cycle");
        req_valid <= 1'b0;
        wait_hold(1'b1);
        chk(bus_lock_out_n === 1'b1, "lock kept in hold");
        hold_req <= 1'b0;
        wait_hold(1'b0);
        $display("test lock done");
    endtask : t_lock
    task automatic t_decode;
        instr <= '{1'b1, 4'h8, 1'b0, 1'b1, 1'b0};
        tick(2);
        chk(prefix_ok === 1'b0, "eight prefixes");
        instr <= '{1'b1, 4'h7, 1'b0, 1'b1, 1'b0};
        tick(2);
        chk(prefix_ok === 1'b1, "seven prefixes");
        instr <= '{1'b1, 4'h0, 1'b0, 1'b1, 1'b1};
        tick(2);
        chk(undef_op === 1'b1, "legacy opcode");
        instr <= '0;
        $display("test decode done");
    endtask : t_decode
    task automatic t_irq;
        bit fast = 0, early = 0, late = 0;
        irq <= 1'b1;
        irq_io_tied <= 1'b1;
        repeat (3) begin
            tick(1);
            fast |= irq_ack === 1'b1;
        end
        chk(fast, "tied interrupt late");
        irq <= 1'b0;
        tick(2);
        irq <= 1'b1;
        irq_io_tied <= 1'b0;
        repeat (PIPE_DEPTH) begin
            tick(1);
            instr_done <= 1'b1;
            early |= irq_ack === 1'b1;
            tick(1);
            instr_done <= 1'b0;
            early |= irq_ack === 1'b1;
        end
        repeat (3) begin
            tick(1);
            late |= irq_ack === 1'b1;
        end
        chk(!early && late, "interrupt latency");
        irq <= 1'b0;
        $display("test interrupt done");
    endtask : t_irq
    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // Main sequence
    initial begin
        {srst, req_valid, instr_done, standby, irq, irq_io_tied} = 6'h21;
        hold_req = 1'b0;
        req = '0;
        instr = '0;
        tick(10);
        srst <= 1'b0;
        tick(1);
        t_kinds();
        t_split();
        t_lock();
        t_decode();
        t_irq();
        final_report();
    end
    // Watchdog
    initial begin
        tick(3000);
        err_total++;
        final_report();
    end
endmodule : tb_top
